// ==== design/hpcw_cfg.svh ====
`ifndef HPCW_CFG_SVH
`define HPCW_CFG_SVH
// Clock rate and the one-second prescale derived from it.
`define HPCW_CLK_PERIOD_NS 4
`define HPCW_NS_PER_SEC 1000000000
`define HPCW_TICK_CYCLES (`HPCW_NS_PER_SEC / `HPCW_CLK_PERIOD_NS)
// Default delays in seconds, swap count and counter widths.
`define HPCW_HB_TIMEOUT_S 60
`define HPCW_REQ_WAIT_S 60
`define HPCW_DOWN_WAIT_S 60
`define HPCW_OFF_TIME_S 5
`define HPCW_SWAP_COUNT 1
`define HPCW_SEC_W 16
`define HPCW_CNT_W 8
`endif

// ==== design/hpcw_pkg.sv ====
package hpcw_pkg;
	typedef enum logic [4:0] {
		HPCW_IDLE = 5'h01,
		HPCW_WATCH = 5'h02,
		HPCW_TIMEOUT = 5'h04,
		HPCW_DOWN_WAIT = 5'h08,
		HPCW_POWER_OFF = 5'h10
	} hpcw_state_type;
endpackage

// ==== design/hpcw_sync.sv ====
`timescale 1ns/1ns
// Three-stage pin synchroniser; a change is taken once stages two and three agree.
module hpcw_sync (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic pin_i,
	output logic level_o
);
	logic s1_ff;
	logic s2_ff;
	logic s3_ff;
	logic level_ff;

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			s1_ff <= 1'b0;
			s2_ff <= 1'b0;
			s3_ff <= 1'b0;
			level_ff <= 1'b0;
		end else begin
			s1_ff <= pin_i;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			if (s2_ff == s3_ff) begin
				level_ff <= s3_ff;
			end
		end
	end

	assign level_o = level_ff;
endmodule

// ==== design/hpcw_top.sv ====
`timescale 1ns/1ns
`include "hpcw_cfg.svh"
// Summary of operation
// - Reset inactive; supervise while enable high, or in armed mode while request high.
// - Every heartbeat edge while watching proves host alive.
// - Over 60 s silence raises timeout pin.
// - Request or 60 s starts 60 s wait.
// - Power cycle cuts supply, pulls run low.
// - Without request, cycle 120 s after timeout.
// - Swap boot card after N consecutive timeouts.
// - Timing and control held in configuration.
// - Host stays unpowered for off time.
// - Armed mode keeps supervision while request high.
module hpcw_top
	import hpcw_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = `HPCW_TICK_CYCLES,
	parameter int unsigned SEC_W = `HPCW_SEC_W,
	parameter int unsigned CNT_W = `HPCW_CNT_W
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic supervise_enable_pin_i,
	input wire logic heartbeat_pin_i,
	input wire logic shutdown_request_pin_i,
	input wire logic [SEC_W-1:0] cfg_hb_timeout_s_i,
	input wire logic [SEC_W-1:0] cfg_req_wait_s_i,
	input wire logic [SEC_W-1:0] cfg_down_wait_s_i,
	input wire logic [SEC_W-1:0] cfg_off_time_s_i,
	input wire logic [CNT_W-1:0] cfg_swap_count_i,
	input wire logic cfg_swap_enable_i,
	input wire logic cfg_arm_mode_i,
	output logic timeout_flag_pin_o,
	output logic host_power_en_o,
	output logic host_run_o,
	output logic boot_alt_card_o
);
	// Elaboration-time check of the parameters that the counters can serve.
	if (TICK_CYCLES < 2 || SEC_W < 4 || CNT_W < 1) begin : g_param_check
		$error("hpcw_top: parameter out of range");
	end

	logic en_s;
	logic hb_s;
	logic req_s;
	logic hb_prev_ff;
	logic req_prev_ff;
	logic [31:0] pre_ff;
	logic tick_ff;
	logic [SEC_W-1:0] sec_ff;
	logic [CNT_W-1:0] tmo_cnt_ff;
	hpcw_state_type state_ff;
	logic timeout_flag_ff;
	logic power_en_ff;
	logic run_ff;
	logic alt_card_ff;
	logic hb_edge;
	logic req_rise;
	logic req_fall;
	logic supervise;
	logic down_start;
	logic tick_restart;

	// Synchronise the three host pins.
	hpcw_sync u_sync_en (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.pin_i(supervise_enable_pin_i),
		.level_o(en_s)
	);
	hpcw_sync u_sync_hb (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.pin_i(heartbeat_pin_i),
		.level_o(hb_s)
	);
	hpcw_sync u_sync_req (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.pin_i(shutdown_request_pin_i),
		.level_o(req_s)
	);

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			hb_prev_ff <= 1'b0;
			req_prev_ff <= 1'b0;
		end else begin
			hb_prev_ff <= hb_s;
			req_prev_ff <= req_s;
		end
	end

	assign hb_edge = hb_s ^ hb_prev_ff;
	assign req_rise = req_s & ~req_prev_ff;
	assign req_fall = ~req_s & req_prev_ff;
	// Armed mode holds supervision up while the request is high.
	assign supervise = en_s | (cfg_arm_mode_i & req_s);
	// Default mode starts on the request rising; armed mode on its fall.
	assign down_start = cfg_arm_mode_i ? req_fall : req_rise;
	// A request restarts the prescaler so that the wait after it is never short.
	assign tick_restart = (state_ff == HPCW_TIMEOUT) && down_start;

	// One-second tick.
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			pre_ff <= 32'h0;
			tick_ff <= 1'b0;
		end else if (tick_restart) begin
			pre_ff <= 32'h0;
			tick_ff <= 1'b0;
		end else if (pre_ff == TICK_CYCLES - 1) begin
			pre_ff <= 32'h0;
			tick_ff <= 1'b1;
		end else begin
			pre_ff <= pre_ff + 32'h1;
			tick_ff <= 1'b0;
		end
	end

	// Main sequence; the seconds counter restarts on every state change.
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			state_ff <= HPCW_IDLE;
			sec_ff <= '0;
		end else begin
			case (state_ff)
				HPCW_IDLE: begin
					sec_ff <= '0;
					if (supervise) begin
						state_ff <= HPCW_WATCH;
					end
				end
				HPCW_WATCH: begin
					if (!supervise) begin
						state_ff <= HPCW_IDLE;
						sec_ff <= '0;
					end else if (hb_edge) begin
						sec_ff <= '0;
					end else if (tick_ff) begin
						if (sec_ff >= cfg_hb_timeout_s_i) begin
							state_ff <= HPCW_TIMEOUT;
							sec_ff <= '0;
						end else begin
							sec_ff <= sec_ff + 1'b1;
						end
					end
				end
				HPCW_TIMEOUT: begin
					// Request or expiry of the wait, whichever first.
					if (down_start || (tick_ff && sec_ff + 1'b1 >= cfg_req_wait_s_i)) begin
						state_ff <= HPCW_DOWN_WAIT;
						sec_ff <= '0;
					end else if (tick_ff) begin
						sec_ff <= sec_ff + 1'b1;
					end
				end
				HPCW_DOWN_WAIT: begin
					if (tick_ff && sec_ff + 1'b1 >= cfg_down_wait_s_i) begin
						state_ff <= HPCW_POWER_OFF;
						sec_ff <= '0;
					end else if (tick_ff) begin
						sec_ff <= sec_ff + 1'b1;
					end
				end
				HPCW_POWER_OFF: begin
					if (tick_ff && sec_ff + 1'b1 >= cfg_off_time_s_i) begin
						state_ff <= HPCW_IDLE;
						sec_ff <= '0;
					end else if (tick_ff) begin
						sec_ff <= sec_ff + 1'b1;
					end
				end
				default: begin
					state_ff <= HPCW_IDLE;
					sec_ff <= '0;
				end
			endcase
		end
	end

	// Pin outputs follow the state.
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			timeout_flag_ff <= 1'b0;
			power_en_ff <= 1'b1;
			run_ff <= 1'b1;
		end else begin
			timeout_flag_ff <= (state_ff == HPCW_TIMEOUT) || (state_ff == HPCW_DOWN_WAIT)
				|| (state_ff == HPCW_POWER_OFF);
			power_en_ff <= (state_ff != HPCW_POWER_OFF);
			run_ff <= (state_ff != HPCW_POWER_OFF);
		end
	end

	// Consecutive timeout count and boot card swap.
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			tmo_cnt_ff <= '0;
			alt_card_ff <= 1'b0;
		end else if (state_ff == HPCW_WATCH && hb_edge) begin
			tmo_cnt_ff <= '0;
		end else if (state_ff == HPCW_WATCH && supervise && tick_ff
				&& sec_ff >= cfg_hb_timeout_s_i) begin
			if (cfg_swap_enable_i && tmo_cnt_ff + 1'b1 >= cfg_swap_count_i
					&& cfg_swap_count_i != '0) begin
				alt_card_ff <= ~alt_card_ff;
				tmo_cnt_ff <= '0;
			end else begin
				tmo_cnt_ff <= tmo_cnt_ff + 1'b1;
			end
		end
	end

	assign timeout_flag_pin_o = timeout_flag_ff;
	assign host_power_en_o = power_en_ff;
	assign host_run_o = run_ff;
	assign boot_alt_card_o = alt_card_ff;

	idle_quiet_a: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i) state_ff == HPCW_IDLE |=> !timeout_flag_pin_o)
		else $error("timeout pin high while idle");
	cycle_pins_a: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i) host_power_en_o == host_run_o)
		else $error("power and run disagree");
	off_flag_a: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i) !host_power_en_o |-> timeout_flag_pin_o)
		else $error("power off without timeout flag");
	timeout_enter_a: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		$rose(state_ff == HPCW_TIMEOUT) |=> timeout_flag_pin_o)
		else $error("timeout pin not raised");
	hb_reset_a: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		state_ff == HPCW_WATCH && supervise && hb_edge |=> sec_ff == '0)
		else $error("heartbeat did not restart timer");
	req_start_a: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		state_ff == HPCW_TIMEOUT && down_start |=> state_ff == HPCW_DOWN_WAIT)
		else $error("request did not start wait");
	off_order_a: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		$rose(state_ff == HPCW_POWER_OFF) |-> $past(state_ff) == HPCW_DOWN_WAIT)
		else $error("power off not preceded by wait");
	off_end_a: assert property (@(posedge core_clk_i)
		disable iff (!rst_n_i)
		$fell(state_ff == HPCW_POWER_OFF) |-> state_ff == HPCW_IDLE)
		else $error("power off left to wrong state");
	timeout_c: cover property (@(posedge core_clk_i) state_ff == HPCW_TIMEOUT);
	arm_start_c: cover property (@(posedge core_clk_i)
		state_ff == HPCW_TIMEOUT && cfg_arm_mode_i && req_fall);
	cycle_c: cover property (@(posedge core_clk_i) !host_power_en_o);
	swap_c: cover property (@(posedge core_clk_i) $rose(boot_alt_card_o));
endmodule

// ==== dv/hpcw_host_model.sv ====
`timescale 1ns/1ns
// Host side of the pins: beats while told to, and asks for shutdown after a timeout.
module hpcw_host_model #(
	parameter int BEAT_GAP = 20
) (
	input wire logic core_clk_i,
	input wire logic beat_on_i,
	input wire logic answer_i,
	input wire logic timeout_flag_pin_i,
	input wire logic host_run_i,
	output logic heartbeat_pin_o,
	output logic shutdown_request_pin_o
);
	int gap = 0;
	logic beat_ff = 1'b0;
	logic ask_ff = 1'b0;
	// A halted host neither beats nor asks, so both stop while the run line is low.
	always @(posedge core_clk_i) begin
		gap <= (gap >= BEAT_GAP) ? 0 : gap + 1;
		if (beat_on_i && host_run_i && gap == BEAT_GAP) begin
			beat_ff <= #1 ~beat_ff;
		end
		ask_ff <= #1 answer_i && host_run_i && timeout_flag_pin_i;
	end
	assign heartbeat_pin_o = beat_ff;
	assign shutdown_request_pin_o = ask_ff;
endmodule

// ==== dv/tb_host_power_cycle_watchdog.sv ====
`timescale 1ns/1ns
`define CHECK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
	$display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module tb_host_power_cycle_watchdog;
	localparam int TK = 10;
	localparam int HB = 3;
	localparam int RQ = 6;
	localparam int DW = 2;
	localparam int OFF = 3;
	localparam int NRQ = (RQ + DW) * TK;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic en = 1'b0;
	logic beat_on = 1'b0;
	logic answer = 1'b0;
	logic swap_en = 1'b1;
	logic arm = 1'b0;
	logic [7:0] swap_cnt = 8'h01;
	logic hb;
	logic req;
	logic flag;
	logic pwr;
	logic run;
	logic card;
	int mismatches = 0;
	int tests_run = 0;
	int n;
	always #2 clk = ~clk;
	hpcw_top #(.TICK_CYCLES(TK)) i_dut (
		.core_clk_i(clk), .rst_n_i(rst_n), .supervise_enable_pin_i(en),
		.heartbeat_pin_i(hb), .shutdown_request_pin_i(req),
		.cfg_hb_timeout_s_i(16'(HB)), .cfg_req_wait_s_i(16'(RQ)),
		.cfg_down_wait_s_i(16'(DW)), .cfg_off_time_s_i(16'(OFF)),
		.cfg_swap_count_i(swap_cnt), .cfg_swap_enable_i(swap_en), .cfg_arm_mode_i(arm),
		.timeout_flag_pin_o(flag), .host_power_en_o(pwr), .host_run_o(run),
		.boot_alt_card_o(card)
	);
	hpcw_host_model i_host (
		.core_clk_i(clk), .beat_on_i(beat_on), .answer_i(answer),
		.timeout_flag_pin_i(flag), .host_run_i(run),
		.heartbeat_pin_o(hb), .shutdown_request_pin_o(req)
	);
	task automatic wait_sig(input bit pick_pwr, input logic v, input int lim);
		n = 0;
		while (((pick_pwr ? pwr : flag) !== v) && n < lim) begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask
	task automatic t_reset();
		`CHECK("flag", 1'b0, flag)
		`CHECK("power", 1'b1, pwr)
		`CHECK("run", 1'b1, run)
		`CHECK("card", 1'b0, card)
		repeat (100) @(posedge clk);
		#1;
		`CHECK("flag off", 1'b0, flag)
	endtask
	task automatic t_alive();
		en = 1'b1;
		beat_on = 1'b1;
		repeat (300) @(posedge clk);
		#1;
		`CHECK("flag alive", 1'b0, flag)
		`CHECK("card alive", 1'b0, card)
	endtask
	task automatic t_cycle(input logic ask, input logic card_exp);
		beat_on = 1'b0;
		answer = ask;
		wait_sig(1'b0, 1'b1, (HB + 3) * TK);
		`CHECK("flag up", 1'b1, flag)
		wait_sig(1'b1, 1'b0, (RQ + DW + 2) * TK);
		if (ask) begin
			`CHECK("down wait", 1'b1, n >= DW * TK && n <= (DW + 1) * TK)
		end else begin
			`CHECK("no request", 1'b1, n >= NRQ - 2 * TK && n <= NRQ + 2)
		end
		`CHECK("run low", 1'b0, run)
		`CHECK("flag held", 1'b1, flag)
		wait_sig(1'b1, 1'b1, (OFF + 2) * TK);
		`CHECK("off time", 1'b1, n >= (OFF - 1) * TK && n <= OFF * TK + 5)
		`CHECK("run back", 1'b1, run)
		`CHECK("flag down", 1'b0, flag)
		`CHECK("card", card_exp, card)
	endtask
	// Armed mode: a raised request must not start the wait; its fall must.
	task automatic t_arm();
		arm = 1'b1;
		answer = 1'b1;
		swap_cnt = 8'h02;
		wait_sig(1'b0, 1'b1, (HB + 3) * TK);
		`CHECK("arm flag", 1'b1, flag)
		repeat (3 * TK) @(posedge clk);
		#1;
		`CHECK("armed hold", 1'b1, pwr)
		answer = 1'b0;
		wait_sig(1'b1, 1'b0, (DW + 2) * TK);
		`CHECK("armed wait", 1'b1, n >= DW * TK && n <= (DW + 1) * TK)
		wait_sig(1'b1, 1'b1, (OFF + 2) * TK);
		`CHECK("armed back", 1'b1, run)
		`CHECK("card kept", 1'b0, card)
		arm = 1'b0;
	endtask
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		#80000;
		mismatches++;
		test_done();
	end
	initial begin
		repeat (10) @(posedge clk);
		#1;
		rst_n = 1'b1;
		t_reset();
		t_alive();
		t_cycle(1'b1, 1'b1);
		t_cycle(1'b0, 1'b0);
		t_arm();
		t_cycle(1'b0, 1'b1);
		test_done();
	end
endmodule
